// ---- msi_regs.sv ----
// Security index, frame debug and channel assessment registers behind an AXI4-Lite slave
//
// Summary of operation
// - 16-bit network identifier in two byte registers, low byte first; standard mode only.
// - MAC security: hardware loads header offset (0 length, 1 frame control).
// - Network security: host writes header offset for standard, hardware for proprietary frames.
// - MAC security: hardware loads 7-bit payload offset where secured payload starts.
// - Network security: host writes payload offset standard frames, hardware for proprietary.
// - 7-bit end offset marks last secured payload position; hardware or software sets it.
// - Disable-auto-indexing stops automatic index loads in transmit mode; host values used.
// - Buffer transmit-process bits run CRC and security without sending; hardware clears them.
// - Buffer receive-process bits run CRC check and security as on reception.
// - Read-only flags show buffer read by transmit and written by receive hardware.
// - Read-only flags show buffer the register bus reads and writes, streaming only.
// - Read-only busy flag holds latest assessment result, 1 busy, 0 silent.
// - Start bit begins assessment; completion clears it, sets irq flag, valid busy.
// - Six-bit energy threshold applies in energy and energy-and-carrier criteria.
// - Energy criteria: busy when mean energy bits 7:2 exceed threshold.
// - Software enables receive chain first; frames still accepted during assessment.
// - Two-bit criterion: 01 energy, 10 carrier, 11 both, 00 either.
`timescale 1ns/1ps
`default_nettype none

module msi_regs
  import msi_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Frame engine side
  input  wire logic              standard_frame_mode,
  input  wire logic              tx_mode,
  input  wire logic              auto_hdr_load,
  input  wire logic [IDX_W-1:0]  auto_hdr_value,
  input  wire logic              auto_pay_load,
  input  wire logic [IDX_W-1:0]  auto_pay_value,
  input  wire logic              auto_end_load,
  input  wire logic [IDX_W-1:0]  auto_end_value,
  input  wire logic              tx_process_done,
  input  wire logic              tx_reading_buffer_flag,
  input  wire logic              rx_writing_buffer_flag,
  input  wire logic              host_reading_buffer_flag,
  input  wire logic              host_writing_buffer_flag,
  output logic                   first_buffer_tx_process,
  output logic                   second_buffer_tx_process,
  output logic                   first_buffer_rx_process,
  output logic                   second_buffer_rx_process,
  output logic [15:0]            network_identifier,
  output logic                   network_id_valid,
  output logic [IDX_W-1:0]       security_header_offset,
  output logic [IDX_W-1:0]       security_payload_offset,
  output logic [IDX_W-1:0]       security_end_offset,
  // Channel assessment side
  input  wire logic              receive_chain_enable,
  input  wire logic              assess_done,
  input  wire logic [7:0]        measured_mean_energy,
  input  wire logic              carrier_detected,
  output logic                   assess_run,
  output logic                   energy_assess_irq_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       net_lo_q, net_hi_q;
  logic [IDX_W-1:0] hdr_q, pay_q, end_q;
  logic             disable_auto_security_indexing_q;
  logic [3:0]       proc_q;
  logic             busy_q;
  logic             start_q;
  logic [THR_W-1:0] thr_q;
  logic [1:0]       crit_q;
  logic             irq_q;
  msi_cca_state_t   st_q, st_d;

  logic             aw_held_q, w_held_q;
  logic [7:0]       aw_idx_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        wr_fire   = clk_en && aw_held_q && w_held_q && !bvalid_q;
  wire        wr_lane0  = w_strb_q[0];
  wire [7:0]  wbyte     = w_data_q[7:0];
  wire        wr_net_lo = wr_fire && wr_lane0 && (aw_idx_q == IDX_NET_ID_LO);
  wire        wr_net_hi = wr_fire && wr_lane0 && (aw_idx_q == IDX_NET_ID_HI);
  wire        wr_hdr    = wr_fire && wr_lane0 && (aw_idx_q == IDX_SEC_HDR);
  wire        wr_pay    = wr_fire && wr_lane0 && (aw_idx_q == IDX_SEC_PAY);
  wire        wr_end    = wr_fire && wr_lane0 && (aw_idx_q == IDX_SEC_END);
  wire        wr_dbg    = wr_fire && wr_lane0 && (aw_idx_q == IDX_DEBUG_CTRL);
  wire        wr_cca    = wr_fire && wr_lane0 && (aw_idx_q == IDX_ASSESS_CTRL);
  wire        wr_mode   = wr_fire && wr_lane0 && (aw_idx_q == IDX_ASSESS_MODE);
  wire        wr_cfg    = wr_fire && wr_lane0 && (aw_idx_q == IDX_SEC_CONFIG);
  wire        wr_hit    = (aw_idx_q >= IDX_NET_ID_LO && aw_idx_q <= IDX_ASSESS_MODE)
                          || (aw_idx_q == IDX_SEC_CONFIG);
  wire        rd_fire   = clk_en && s_axi_arvalid && !rvalid_q;
  wire [7:0]  ar_idx    = s_axi_araddr[ADDR_W-1:2];

  // ----------------------------------------------------------------
  // Security index update
  // ----------------------------------------------------------------
  wire auto_block = disable_auto_security_indexing_q && tx_mode;
  wire hdr_hw     = auto_hdr_load && !auto_block;
  wire pay_hw     = auto_pay_load && !auto_block;
  wire end_hw     = auto_end_load && !auto_block;

  // ----------------------------------------------------------------
  // Channel assessment
  // ----------------------------------------------------------------
  wire energy_hit  = measured_mean_energy[7:2] > thr_q;
  wire busy_result = (crit_q == CRIT_ED)        ? energy_hit :
                     (crit_q == CRIT_CS)        ? carrier_detected :
                     (crit_q == CRIT_ED_AND_CS) ? (energy_hit && carrier_detected) :
                                                  (energy_hit || carrier_detected);
  wire cca_finish  = (st_q == MSI_MEASURE) && assess_done;
  wire sw_start    = wr_cca && wbyte[CCA_ST_BIT];

  always_comb begin
    st_d = st_q;
    case (st_q)
      MSI_IDLE:    if (start_q && receive_chain_enable) begin
        st_d = MSI_MEASURE;
      end
      MSI_MEASURE: if (assess_done) begin
        st_d = MSI_DONE;
      end
      MSI_DONE:    st_d = MSI_IDLE;
      default:     st_d = MSI_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_lo_q <= RST_NET_BYTE;
      net_hi_q <= RST_NET_BYTE;
      hdr_q    <= RST_INDEX;
      pay_q    <= RST_INDEX;
      end_q    <= RST_INDEX;
      disable_auto_security_indexing_q   <= 1'b0;
      proc_q   <= 4'h0;
    end else if (clk_en) begin
      if (wr_net_lo) net_lo_q <= wbyte;
      if (wr_net_hi) net_hi_q <= wbyte;
      if (hdr_hw) hdr_q <= auto_hdr_value;
      else if (wr_hdr) hdr_q <= wbyte[IDX_W-1:0];
      if (pay_hw) pay_q <= auto_pay_value;
      else if (wr_pay) pay_q <= wbyte[IDX_W-1:0];
      if (end_hw) end_q <= auto_end_value;
      else if (wr_end) end_q <= wbyte[IDX_W-1:0];
      if (wr_cfg) disable_auto_security_indexing_q <= wbyte[0];
      if (wr_dbg) begin
        proc_q <= wbyte[DBG_TX1_BIT:DBG_RX2_BIT];
      end else if (tx_process_done) begin
        proc_q[3:2] <= 2'b00;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q  <= 1'b0;
      start_q <= 1'b0;
      thr_q   <= RST_ASSESS_CTRL[THR_W-1:0];
      crit_q  <= RST_CRIT;
      irq_q   <= 1'b0;
      st_q    <= MSI_IDLE;
    end else if (clk_en) begin
      st_q <= st_d;
      if (wr_cca) thr_q <= wbyte[THR_W-1:0];
      if (wr_mode) crit_q <= wbyte[1:0];
      if (cca_finish) begin
        busy_q  <= busy_result;
        start_q <= 1'b0;
        irq_q   <= 1'b1;
      end else begin
        if (wr_cca) start_q <= wbyte[CCA_ST_BIT];
        if (sw_start) irq_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = clk_en && !aw_held_q && !bvalid_q;
  assign s_axi_wready  = clk_en && !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire [7:0] dbg_rd = {proc_q, tx_reading_buffer_flag, rx_writing_buffer_flag,
                       host_reading_buffer_flag, host_writing_buffer_flag};
  wire [7:0] cca_rd = {busy_q, start_q, thr_q};
  logic [7:0] rd_byte;
  logic       rd_hit;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (ar_idx)
      IDX_NET_ID_LO:   rd_byte = net_lo_q;
      IDX_NET_ID_HI:   rd_byte = net_hi_q;
      IDX_SEC_HDR:     rd_byte = {1'b0, hdr_q};
      IDX_SEC_PAY:     rd_byte = {1'b0, pay_q};
      IDX_SEC_END:     rd_byte = {1'b0, end_q};
      IDX_DEBUG_CTRL:  rd_byte = dbg_rd;
      IDX_ASSESS_CTRL: rd_byte = cca_rd;
      IDX_ASSESS_MODE: rd_byte = {6'h00, crit_q};
      IDX_SEC_CONFIG:  rd_byte = {6'h00, irq_q, disable_auto_security_indexing_q};
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rd_byte};
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_arready = clk_en && !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ----------------------------------------------------------------
  // Outputs to the frame engine and channel assessment
  // ----------------------------------------------------------------
  assign first_buffer_tx_process  = proc_q[3];
  assign second_buffer_tx_process = proc_q[2];
  assign first_buffer_rx_process  = proc_q[1];
  assign second_buffer_rx_process = proc_q[0];
  assign network_identifier       = {net_hi_q, net_lo_q};
  assign network_id_valid         = standard_frame_mode;
  assign security_header_offset   = hdr_q;
  assign security_payload_offset  = pay_q;
  assign security_end_offset      = end_q;
  assign assess_run               = (st_q == MSI_MEASURE);
  assign energy_assess_irq_flag   = irq_q;

endmodule // msi_regs

`default_nettype wire

// ---- msi_pkg.sv ----
// Package of offsets, field positions and reset values for the security index and assessment registers
package msi_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_NET_ID_LO     = 8'h29;
  localparam logic [7:0] IDX_NET_ID_HI     = 8'h2A;
  localparam logic [7:0] IDX_SEC_HDR       = 8'h2B;
  localparam logic [7:0] IDX_SEC_PAY       = 8'h2C;
  localparam logic [7:0] IDX_SEC_END       = 8'h2D;
  localparam logic [7:0] IDX_DEBUG_CTRL    = 8'h2E;
  localparam logic [7:0] IDX_ASSESS_CTRL   = 8'h2F;
  localparam logic [7:0] IDX_ASSESS_MODE   = 8'h30;
  localparam logic [7:0] IDX_SEC_CONFIG    = 8'h40;

  localparam int unsigned ADDR_W = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned DBG_TX1_BIT  = 7;
  localparam int unsigned DBG_TX2_BIT  = 6;
  localparam int unsigned DBG_RX1_BIT  = 5;
  localparam int unsigned DBG_RX2_BIT  = 4;
  localparam int unsigned DBG_TXRD_BIT = 3;
  localparam int unsigned DBG_RXWR_BIT = 2;
  localparam int unsigned DBG_BRD_BIT  = 1;
  localparam int unsigned DBG_BWR_BIT  = 0;
  localparam int unsigned CCA_BUSY_BIT = 7;
  localparam int unsigned CCA_ST_BIT   = 6;
  localparam int unsigned THR_W        = 6;
  localparam int unsigned IDX_W        = 7;

  // ----------------------------------------------------------------
  // Reset values and assessment criteria
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ASSESS_CTRL  = 8'h0C;
  localparam logic [7:0] RST_NET_BYTE     = 8'h00;
  localparam logic [6:0] RST_INDEX        = 7'h00;
  localparam logic [1:0] RST_CRIT         = 2'b01;
  localparam logic [1:0] CRIT_ED_OR_CS    = 2'b00;
  localparam logic [1:0] CRIT_ED          = 2'b01;
  localparam logic [1:0] CRIT_CS          = 2'b10;
  localparam logic [1:0] CRIT_ED_AND_CS   = 2'b11;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MSI_IDLE    = 2'b00,
    MSI_MEASURE = 2'b01,
    MSI_DONE    = 2'b10
  } msi_cca_state_t;

endpackage

// ---- msi_regs_properties.sv ----
// Concurrent checks on the security index and channel assessment register block
`timescale 1ns/1ps
`default_nettype none

module msi_regs_checker
  import msi_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             clk_en,
  input wire logic             standard_frame_mode,
  input wire logic             network_id_valid,
  input wire logic             tx_mode,
  input wire logic             auto_hdr_load,
  input wire logic [IDX_W-1:0] auto_hdr_value,
  input wire logic             auto_pay_load,
  input wire logic [IDX_W-1:0] auto_pay_value,
  input wire logic             auto_end_load,
  input wire logic [IDX_W-1:0] auto_end_value,
  input wire logic [IDX_W-1:0] security_header_offset,
  input wire logic [IDX_W-1:0] security_payload_offset,
  input wire logic [IDX_W-1:0] security_end_offset,
  input wire logic             tx_process_done,
  input wire logic             first_buffer_tx_process,
  input wire logic             second_buffer_tx_process,
  input wire logic             receive_chain_enable,
  input wire logic             assess_done,
  input wire logic             assess_run,
  input wire logic             energy_assess_irq_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  id_valid_a: assert property (network_id_valid == standard_frame_mode)
    else $error("network id valid differs from frame mode");
  hdr_load_a: assert property (clk_en && auto_hdr_load && !tx_mode |=>
    security_header_offset == $past(auto_hdr_value)) else $error("header offset not loaded");
  pay_load_a: assert property (clk_en && auto_pay_load && !tx_mode |=>
    security_payload_offset == $past(auto_pay_value)) else $error("payload offset not loaded");
  end_load_a: assert property (clk_en && auto_end_load && !tx_mode |=>
    security_end_offset == $past(auto_end_value)) else $error("end offset not loaded");
  tx_clear_a: assert property (clk_en && tx_process_done |=>
    !first_buffer_tx_process && !second_buffer_tx_process) else $error("tx process bits not cleared");
  done_irq_a: assert property (clk_en && assess_run && assess_done |=>
    energy_assess_irq_flag && !assess_run) else $error("completion did not set flag");
  run_hold_a: assert property (assess_run && !(clk_en && assess_done) |=> assess_run)
    else $error("assessment ended without completion");
  run_gate_a: assert property ($rose(assess_run) |-> $past(receive_chain_enable))
    else $error("assessment ran with receive chain off");
endmodule // msi_regs_checker

bind msi_regs msi_regs_checker u_msi_regs_checker (
  .aclk, .aresetn, .clk_en, .standard_frame_mode, .network_id_valid, .tx_mode,
  .auto_hdr_load, .auto_hdr_value, .auto_pay_load, .auto_pay_value, .auto_end_load, .auto_end_value,
  .security_header_offset, .security_payload_offset, .security_end_offset, .tx_process_done,
  .first_buffer_tx_process, .second_buffer_tx_process, .receive_chain_enable, .assess_done,
  .assess_run, .energy_assess_irq_flag
);

`default_nettype wire

// ---- tb_msi_regs.sv ----
// Self-checking bench for the security index and channel assessment register block
`timescale 1ns/1ps
`default_nettype none

module tb_msi_regs;
  import msi_pkg::*;

  logic              aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              standard_frame_mode, tx_mode, auto_hdr_load, auto_pay_load, auto_end_load, tx_process_done;
  logic [IDX_W-1:0]  auto_hdr_value, auto_pay_value, auto_end_value;
  logic [IDX_W-1:0]  security_header_offset, security_payload_offset, security_end_offset;
  logic              tx_reading_buffer_flag, rx_writing_buffer_flag, host_reading_buffer_flag;
  logic              host_writing_buffer_flag, first_buffer_tx_process, second_buffer_tx_process;
  logic              first_buffer_rx_process, second_buffer_rx_process, network_id_valid;
  logic              receive_chain_enable, assess_done, carrier_detected, assess_run, energy_assess_irq_flag;
  logic [15:0]       network_identifier;
  logic [7:0]        measured_mean_energy;
  int                n_fail, cmp_count;

  msi_regs u_msi_regs (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standard_frame_mode, .tx_mode,
    .auto_hdr_load, .auto_hdr_value, .auto_pay_load, .auto_pay_value, .auto_end_load, .auto_end_value,
    .tx_process_done, .tx_reading_buffer_flag, .rx_writing_buffer_flag, .host_reading_buffer_flag,
    .host_writing_buffer_flag, .first_buffer_tx_process, .second_buffer_tx_process, .first_buffer_rx_process,
    .second_buffer_rx_process, .network_identifier, .network_id_valid, .security_header_offset,
    .security_payload_offset, .security_end_offset, .receive_chain_enable, .assess_done,
    .measured_mean_energy, .carrier_detected, .assess_run, .energy_assess_irq_flag
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  function automatic logic exp_busy(input logic [1:0] c, input logic [7:0] e, input logic [5:0] t, input logic cs);
    logic ed;
    ed = e[7:2] > t;
    case (c)
      CRIT_ED:        return ed;
      CRIT_CS:        return cs;
      CRIT_ED_AND_CS: return ed & cs;
      default:        return ed | cs;
    endcase
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    close_out();
  end

  initial begin
    logic [31:0] r, x;
    logic [5:0]  thr;
    logic [1:0]  crit;
    logic [7:0]  d;
    logic        bz, cd;
    int          i;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, standard_frame_mode, tx_mode} = '0;
    {auto_hdr_load, auto_pay_load, auto_end_load, tx_process_done, assess_done, carrier_detected} = '0;
    {tx_reading_buffer_flag, rx_writing_buffer_flag, host_reading_buffer_flag, host_writing_buffer_flag} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, auto_hdr_value, auto_pay_value, auto_end_value} = '0;
    {clk_en, s_axi_bready, s_axi_rready, receive_chain_enable} = 4'hF;
    s_axi_wstrb = 4'h1;
    measured_mean_energy = 8'h00;
    bz = 1'b0;
    r = $urandom(32'h0000_8c47);
    tick(8);
    aresetn <= 1'b1;
    tick(1);
    for (i = 8'h29; i <= 8'h30; i++) begin
      rd("reset", 8'(i), i == 8'h2F ? 32'h0000_000C : (i == 8'h30 ? 32'h0000_0001 : 32'h0), RESP_OKAY);
    end
    rd("unmapped", 8'h31, 32'h0, RESP_SLVERR);
    wr(8'h3F, 8'hFF, RESP_SLVERR);
    r = $urandom;
    wr(IDX_NET_ID_LO, r[7:0], RESP_OKAY);
    wr(IDX_NET_ID_HI, r[15:8], RESP_OKAY);
    standard_frame_mode <= 1'b1;
    chk("net_id", {16'h0, r[15:0]}, {16'h0, network_identifier});
    rd("net_hi", IDX_NET_ID_HI, {24'h00_0000, r[15:8]}, RESP_OKAY);
    chk("id_valid", 32'h1, {31'h0, network_id_valid});
    for (i = 0; i < 3; i++) begin
      d = 8'($urandom) & 8'h7F;
      wr(IDX_SEC_HDR + 8'(i), d, RESP_OKAY);
      rd("sec_idx", IDX_SEC_HDR + 8'(i), {25'h0, d[6:0]}, RESP_OKAY);
    end
    for (i = 0; i < 3; i++) begin
      if (i == 1) wr(IDX_SEC_CONFIG, 8'h01, RESP_OKAY);
      tx_mode <= (i == 1);
      r = $urandom;
      {auto_hdr_value, auto_pay_value, auto_end_value} <= {r[6:0], r[14:8], r[22:16]};
      {auto_hdr_load, auto_pay_load, auto_end_load} <= 3'b111;
      tick(1);
      {auto_hdr_load, auto_pay_load, auto_end_load} <= 3'b000;
      tick(1);
      if (i != 1) x = r;
      chk("hdr_idx", {25'h0, x[6:0]}, {25'h0, security_header_offset});
      chk("pay_idx", {25'h0, x[14:8]}, {25'h0, security_payload_offset});
      chk("end_idx", {25'h0, x[22:16]}, {25'h0, security_end_offset});
    end
    rd("config", IDX_SEC_CONFIG, 32'h1, RESP_OKAY);
    wr(IDX_SEC_CONFIG, 8'h00, RESP_OKAY);
    tx_mode <= 1'b0;
    wr(IDX_DEBUG_CTRL, 8'hF0, RESP_OKAY);
    wr(IDX_SEC_END, 8'h15, RESP_OKAY);
    r = $urandom;
    {tx_reading_buffer_flag, rx_writing_buffer_flag, host_reading_buffer_flag, host_writing_buffer_flag} <= r[3:0];
    rd("debug", IDX_DEBUG_CTRL, {24'h00_0000, 4'hF, r[3:0]}, RESP_OKAY);
    chk("proc", 32'hF, {first_buffer_tx_process, second_buffer_tx_process, first_buffer_rx_process, second_buffer_rx_process});
    tx_process_done <= 1'b1;
    tick(1);
    tx_process_done <= 1'b0;
    tick(1);
    rd("debug", IDX_DEBUG_CTRL, {24'h00_0000, 4'h3, r[3:0]}, RESP_OKAY);
    wr(IDX_DEBUG_CTRL, 8'h00, RESP_OKAY);
    receive_chain_enable <= 1'b0;
    for (i = 0; i < 12; i++) begin
      r = $urandom;
      crit = (i < 2) ? CRIT_ED : 2'(i);
      thr = (i < 2) ? 6'h0C : r[5:0];
      d = (i == 0) ? 8'h30 : ((i == 1) ? 8'h34 : r[15:8]);
      cd = (i < 2) ? 1'b0 : r[16];
      wr(IDX_ASSESS_MODE, {6'h00, crit}, RESP_OKAY);
      wr(IDX_ASSESS_CTRL, {2'b01, thr}, RESP_OKAY);
      if (i == 0) begin
        chk("run_off", 32'h0, {31'h0, assess_run});
        rd("start_wait", IDX_ASSESS_CTRL, {24'h00_0000, 2'b01, thr}, RESP_OKAY);
        receive_chain_enable <= 1'b1;
      end
      while (assess_run !== 1'b1) tick(1);
      chk("irq_clr", 32'h0, {31'h0, energy_assess_irq_flag});
      {measured_mean_energy, carrier_detected, assess_done} <= {d, cd, 1'b1};
      tick(1);
      {measured_mean_energy, carrier_detected, assess_done} <= {~d, ~cd, 1'b0};
      tick(1);
      bz = exp_busy(crit, d, thr, cd);
      chk("irq", 32'h1, {31'h0, energy_assess_irq_flag});
      rd("assess", IDX_ASSESS_CTRL, {24'h00_0000, bz, 1'b0, thr}, RESP_OKAY);
      rd("irq_bit", IDX_SEC_CONFIG, 32'h2, RESP_OKAY);
    end
    wr(IDX_ASSESS_CTRL, 8'h3F, RESP_OKAY);
    rd("busy_hold", IDX_ASSESS_CTRL, {24'h00_0000, bz, 7'h3F}, RESP_OKAY);
    close_out();
  end
endmodule // tb_msi_regs

`default_nettype wire
